// ==== hw/evp_top.sv ====
// exception vector priority unit with apb register slave
//
// Summary of operation
// R01: base is register byte then zero
// R02: spurious vector at base plus 0x80
// R03: low sources 0x82..0xf2, higher wins
// R04: slot 0xf2 is external pin request
// R05: high-mask request at base plus 0xf4
// R06: soft trap or debug at 0xf6
// R07: opcode trap at 0xf8, top nonreset
// R08: fixed reset vectors fffe fffc fffa
// R09: base register resets to 0xff
// R10: reset vectors ignore base register
// R11: debug active forces upper byte ff
// R12: highest vector address wins
// R13: low request needs enable, flag, nothing higher
// R14: unmasked requests outrank low requests
// R15: priority resolved at vector request
// R16: nothing pending returns spurious vector
// R17: peripherals hold requests until service
// R18: wake-up signalled with clock off
// R19: stop wakes only async, low flag blocks
// R20: high request wakes despite its mask
// R21: base register on simple register port
// R22: vector valid next cycle, held stable
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module evp_top
	import evp_pkg::*;
(
	input  wire logic                        I_REF_CLK,
	input  wire logic                        I_SYS_RST,
	input  wire logic                        i_psel,
	input  wire logic                        i_penable,
	input  wire logic                        i_pwrite,
	input  wire logic [11:0]                 i_paddr,
	input  wire logic [31:0]                 i_pwdata,
	input  wire logic [3:0]                  i_pstrb,
	output logic                             o_pready,
	output logic                             o_pslverr,
	output logic [31:0]                      o_prdata,
	input  wire logic [evp_pkg::LOW_SOURCES-1:0] i_low_req,
	input  wire logic [evp_pkg::LOW_SOURCES-1:0] i_low_enable,
	input  wire logic [evp_pkg::LOW_SOURCES-1:0] i_low_async,
	input  wire logic                        i_ext_pin_req,
	input  wire logic                        i_die_link_req,
	input  wire logic                        i_die_link_present,
	input  wire logic                        i_nonmaskable_pin_request,
	input  wire logic                        i_die_link_error_req,
	input  wire logic                        i_soft_trap_instruction,
	input  wire logic                        i_background_debug_mode_req,
	input  wire logic                        i_opcode_trap,
	input  wire logic                        i_reset_main,
	input  wire logic                        i_reset_clock_monitor,
	input  wire logic                        i_reset_watchdog_timeout,
	input  wire logic                        i_low_mask_flag,
	input  wire logic                        i_high_mask_flag,
	input  wire logic                        i_debug_active,
	input  wire logic                        i_wait_mode,
	input  wire logic                        i_stop_mode,
	input  wire logic                        i_vector_req,
	output logic                             o_vector_valid,
	output logic [15:0]                      o_vector,
	output logic                             o_wake,
	output logic                             o_wake_enter_service
);
	// ----------------------------------------
	// request qualification
	// ----------------------------------------
	logic [LOW_SOURCES-1:0] low_qual;
	logic                   low_any;
	logic                   low_any_async;
	logic [7:0]             low_offset;
	logic                   slot_f2_req;
	logic                   high_req;
	logic                   soft_req;
	logic                   higher_pending;

	always_comb
	begin
		// external pin or die-link on the top maskable slot
		slot_f2_req = i_die_link_present ? i_die_link_req : i_ext_pin_req; // R04
		high_req = i_die_link_present ? i_die_link_error_req
			: i_nonmaskable_pin_request; // R05
		soft_req = i_soft_trap_instruction || i_background_debug_mode_req; // R06
		higher_pending = soft_req || i_opcode_trap || (high_req && !i_high_mask_flag); // R13 R14
		low_qual = '0;
		for (int k = 0; k < LOW_SOURCES - 1; k++)
		begin
			low_qual[k] = i_low_req[k] && i_low_enable[k]; // R13
		end
		low_qual[LOW_SOURCES-1] = slot_f2_req && i_low_enable[LOW_SOURCES-1];
		low_any_async = |(low_qual & i_low_async);
	end

	evp_low_prio u_low_prio
	(
		.i_req    (low_qual),
		.o_any    (low_any),
		.o_offset (low_offset)
	);

	evp_wake u_wake
	(
		.i_stop          (i_stop_mode),
		.i_low_mask      (i_low_mask_flag),
		.i_any_low       (low_any),
		.i_any_low_async (low_any_async),
		.i_high_req      (high_req),
		.i_high_mask     (i_high_mask_flag),
		.o_wake          (o_wake),
		.o_enter_service (o_wake_enter_service)
	);

	// ----------------------------------------
	// base register over apb
	// ----------------------------------------
	logic [7:0] vector_base_upper;
	logic [7:0] next_vector_base_upper;
	logic [31:0] prdata;
	logic [31:0] next_prdata;
	logic        pslverr;
	logic        next_pslverr;
	logic        apb_access;
	logic        addr_ok;

	always_comb
	begin
		apb_access = i_psel && i_penable;
		addr_ok = (i_paddr == VECTOR_BASE_UPPER_ADDR) || (i_paddr == STATUS_ADDR);
		next_vector_base_upper = vector_base_upper;
		next_prdata = prdata;
		next_pslverr = 1'b0;
		if (i_psel && !i_penable)
		begin
			next_pslverr = !addr_ok || (i_pwrite && i_paddr == STATUS_ADDR);
			next_prdata = 32'h0000_0000;
			if (!i_pwrite && i_paddr == VECTOR_BASE_UPPER_ADDR)
				next_prdata = {24'h000000, vector_base_upper};
			if (!i_pwrite && i_paddr == STATUS_ADDR)
				next_prdata = {26'h0000000, high_req, soft_req, i_opcode_trap,
					low_any, o_vector_valid, i_debug_active};
		end
		else if (apb_access)
		begin
			next_pslverr = pslverr;
		end
		if (apb_access && i_pwrite && i_paddr == VECTOR_BASE_UPPER_ADDR && i_pstrb[0])
			next_vector_base_upper = i_pwdata[7:0]; // R09 R21
	end

	always_ff @(posedge I_REF_CLK)
	begin
		if (I_SYS_RST)
		begin
			vector_base_upper <= VECTOR_BASE_UPPER_RESET; // R09 R10
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			vector_base_upper <= next_vector_base_upper;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// setup cycle captures read data, access completes at once
	assign o_pready  = 1'b1;
	assign o_pslverr = apb_access && pslverr;
	assign o_prdata  = prdata;

	// ----------------------------------------
	// vector resolution
	// ----------------------------------------
	logic [7:0]  upper_byte;
	logic [7:0]  win_offset;
	logic        reset_hit;
	logic [15:0] reset_vector;
	logic [15:0] resolved;

	always_comb
	begin
		upper_byte = i_debug_active ? DEBUG_UPPER_BYTE : vector_base_upper; // R11 R01
		reset_hit = 1'b1;
		reset_vector = VEC_RESET_MAIN;
		if (i_reset_main)
			reset_vector = VEC_RESET_MAIN; // R08 R10
		else if (i_reset_clock_monitor)
			reset_vector = VEC_RESET_CLK; // R08
		else if (i_reset_watchdog_timeout)
			reset_vector = VEC_RESET_WDOG; // R08
		else
			reset_hit = 1'b0;
		// highest vector address first
		if (i_opcode_trap)
			win_offset = OFS_OPCODE; // R07 R12
		else if (soft_req)
			win_offset = OFS_SOFT_TRAP; // R06 R12
		else if (high_req && !i_high_mask_flag)
			win_offset = OFS_HIGH_MASK; // R05 R14
		else if (low_any && !i_low_mask_flag && !higher_pending)
			win_offset = low_offset; // R13 R03
		else
			win_offset = OFS_SPURIOUS; // R02 R16
		resolved = reset_hit ? reset_vector : {upper_byte, BASE_LOW_BYTE}; // R01
	end

	// ----------------------------------------
	// vector answer to the core
	// ----------------------------------------
	evp_state_t  state;
	evp_state_t  next_state;
	logic [15:0] vector;
	logic [15:0] next_vector;
	logic        valid;
	logic        next_valid;

	always_comb
	begin
		next_state = state;
		next_vector = vector;
		next_valid = valid;
		case (state)
			EVP_IDLE:
			begin
				next_valid = 1'b0;
				if (i_vector_req)
				begin
					next_state = EVP_HOLD;
					next_valid = 1'b1; // R22
					// resolve now, not at recognition
					next_vector = reset_hit ? resolved
						: {upper_byte, win_offset}; // R15
				end
			end
			EVP_HOLD:
			begin
				if (!i_vector_req)
				begin
					next_state = EVP_IDLE;
					next_valid = 1'b0;
				end
			end
			default:
			begin
				next_state = EVP_IDLE;
				next_valid = 1'b0;
			end
		endcase
	end

	always_ff @(posedge I_REF_CLK)
	begin
		if (I_SYS_RST)
		begin
			state <= EVP_IDLE;
			vector <= VEC_RESET_MAIN;
			valid <= 1'b0;
		end
		else
		begin
			state <= next_state;
			vector <= next_vector; // R22
			valid <= next_valid;
		end
	end

	assign o_vector       = vector;
	assign o_vector_valid = valid;
endmodule
`default_nettype wire

// ==== common/evp_pkg.sv ====
// package: constants and types for the exception vector priority unit
`default_nettype none
package evp_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [11:0] VECTOR_BASE_UPPER_ADDR  = 12'h000;
	localparam logic [11:0] STATUS_ADDR             = 12'h004;
	localparam logic [7:0]  VECTOR_BASE_UPPER_RESET = 8'hff;
	localparam logic [7:0]  DEBUG_UPPER_BYTE        = 8'hff;
	localparam logic [7:0]  BASE_LOW_BYTE           = 8'h00;
	// ----------------------------------------
	// vector offsets and fixed vectors
	// ----------------------------------------
	localparam logic [7:0]  OFS_SPURIOUS   = 8'h80;
	localparam logic [7:0]  OFS_LOW_FIRST  = 8'h82;
	localparam logic [7:0]  OFS_EXT_PIN    = 8'hf2;
	localparam logic [7:0]  OFS_HIGH_MASK  = 8'hf4;
	localparam logic [7:0]  OFS_SOFT_TRAP  = 8'hf6;
	localparam logic [7:0]  OFS_OPCODE     = 8'hf8;
	localparam logic [15:0] VEC_RESET_MAIN = 16'hfffe;
	localparam logic [15:0] VEC_RESET_CLK  = 16'hfffc;
	localparam logic [15:0] VEC_RESET_WDOG = 16'hfffa;
	// number of low-mask-flag sources, 0x82..0xf2 step 2
	localparam int          LOW_SOURCES    = 57;
	localparam logic [2:0]  RESET_SOURCES  = 3'd3;
	// ----------------------------------------
	// vector answer states
	// ----------------------------------------
	typedef enum logic [1:0] {EVP_IDLE, EVP_HOLD} evp_state_t;
endpackage
`default_nettype wire

// ==== hw/evp_low_prio.sv ====
// priority encoder for low-mask-flag sources
`timescale 1ns/100ps
`default_nettype none
module evp_low_prio
	import evp_pkg::*;
(
	input  wire logic [LOW_SOURCES-1:0] i_req,
	output logic                        o_any,
	output logic [7:0]                  o_offset
);
	// ----------------------------------------
	// highest index wins
	// ----------------------------------------
	always_comb
	begin
		o_any    = 1'b0;
		o_offset = OFS_SPURIOUS;
		for (int k = 0; k < LOW_SOURCES; k++)
		begin
			if (i_req[k])
			begin
				o_any    = 1'b1;
				o_offset = 8'(OFS_LOW_FIRST + 8'(2 * k)); // R03
			end
		end
	end
endmodule
`default_nettype wire

// ==== hw/evp_wake.sv ====
// wake-up qualification for wait and stop, works without clock
`timescale 1ns/100ps
`default_nettype none
module evp_wake
	import evp_pkg::*;
(
	input  wire logic                   i_stop,
	input  wire logic                   i_low_mask,
	input  wire logic                   i_any_low,
	input  wire logic                   i_any_low_async,
	input  wire logic                   i_high_req,
	input  wire logic                   i_high_mask,
	output logic                        o_wake,
	output logic                        o_enter_service
);
	// ----------------------------------------
	// combinational wake
	// ----------------------------------------
	logic low_ok;
	always_comb
	begin
		low_ok = !i_low_mask && (i_stop ? i_any_low_async : i_any_low); // R19
		o_wake = low_ok || i_high_req; // R18 R20
		o_enter_service = low_ok || (i_high_req && !i_high_mask); // R20
	end
endmodule
`default_nettype wire

// ==== bench/evp_core_model.sv ====
// core side model that fetches exception vectors
`timescale 1ns/100ps
`default_nettype none
module evp_core_model (
	input  wire logic clk,
	input  wire logic vld,
	output logic      req
);
	initial req = 1'b0;
	// one fetch, slow keeps the request longer
	task automatic fetch(input int slow);
		@(posedge clk);
		req <= 1'b1;
		do @(posedge clk); while (vld !== 1'b1);
		repeat (slow) @(posedge clk);
		req <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// ==== bench/evp_top_monitor.sv ====
// port assertions for the vector priority unit
`timescale 1ns/100ps
`default_nettype none
module evp_top_monitor (
	input wire logic        I_REF_CLK,
	input wire logic        I_SYS_RST,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic [11:0] i_paddr,
	input wire logic        o_pslverr,
	input wire logic        i_vector_req,
	input wire logic        o_vector_valid,
	input wire logic [15:0] o_vector,
	input wire logic        i_reset_main,
	input wire logic        i_reset_clock_monitor,
	input wire logic        i_reset_watchdog_timeout,
	input wire logic        i_opcode_trap,
	input wire logic        i_debug_active
);
	wire nr = !(i_reset_main | i_reset_clock_monitor | i_reset_watchdog_timeout);
	wire rq = i_vector_req;
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (I_SYS_RST);
	property p_valid; $rose(rq) |=> o_vector_valid; endproperty
	a_valid: assert property (p_valid) else $error("no valid after request");
	property p_hold; o_vector_valid && rq |=> o_vector_valid && $stable(o_vector); endproperty
	a_hold: assert property (p_hold) else $error("vector not held");
	property p_drop; !rq |=> !o_vector_valid; endproperty
	a_drop: assert property (p_drop) else $error("valid after request left");
	property p_rst; $rose(rq) && i_reset_main |=> o_vector == 16'hfffe; endproperty
	a_rst: assert property (p_rst) else $error("main reset vector wrong");
	property p_wdog;
		$rose(rq) && i_reset_watchdog_timeout && !i_reset_main && !i_reset_clock_monitor
		|=> o_vector == 16'hfffa;
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog vector wrong");
	property p_trap; $rose(rq) && nr && i_opcode_trap |=> o_vector[7:0] == 8'hf8; endproperty
	a_trap: assert property (p_trap) else $error("opcode trap not on top");
	property p_dbg; $rose(rq) && nr && i_debug_active |=> o_vector[15:8] == 8'hff; endproperty
	a_dbg: assert property (p_dbg) else $error("debug upper byte wrong");
	property p_err; i_psel && i_penable && i_paddr > 12'h004 |-> o_pslverr; endproperty
	a_err: assert property (p_err) else $error("unmapped access accepted");
endmodule
bind evp_top evp_top_monitor u_mon
(
	.I_REF_CLK                (I_REF_CLK),
	.I_SYS_RST                (I_SYS_RST),
	.i_psel                   (i_psel),
	.i_penable                (i_penable),
	.i_paddr                  (i_paddr),
	.o_pslverr                (o_pslverr),
	.i_vector_req             (i_vector_req),
	.o_vector_valid           (o_vector_valid),
	.o_vector                 (o_vector),
	.i_reset_main             (i_reset_main),
	.i_reset_clock_monitor    (i_reset_clock_monitor),
	.i_reset_watchdog_timeout (i_reset_watchdog_timeout),
	.i_opcode_trap            (i_opcode_trap),
	.i_debug_active           (i_debug_active)
);
`default_nettype wire

// ==== bench/tb_exception_vector_priority.sv ====
// self-checking bench for the vector priority unit
`timescale 1ns/100ps
`default_nettype none
module tb_exception_vector_priority;
	import evp_pkg::*;
	logic                   I_REF_CLK = 0, I_SYS_RST = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
	logic [11:0]            i_paddr = '0;
	logic [31:0]            i_pwdata = '0, o_prdata, rng = 32'hb69afc4a, q[$], eq[$];
	logic [3:0]             i_pstrb = 4'h1;
	logic [LOW_SOURCES-1:0] i_low_req, i_low_enable, i_low_async, one = 1;
	logic                   i_ext_pin_req, i_die_link_req, i_die_link_present;
	logic                   i_nonmaskable_pin_request, i_die_link_error_req, i_opcode_trap;
	logic                   i_soft_trap_instruction, i_background_debug_mode_req, i_reset_main;
	logic                   i_reset_clock_monitor, i_reset_watchdog_timeout, i_low_mask_flag;
	logic                   i_high_mask_flag, i_debug_active, i_wait_mode, i_stop_mode, vd;
	logic                   i_vector_req, o_pready, o_pslverr, o_vector_valid, o_wake;
	logic                   o_wake_enter_service;
	logic [15:0]            o_vector;
	logic [7:0]             base = 8'hff;
	int                     error_cnt = 0, n_tests = 0, k;
	evp_top u_dut
	(
		.I_REF_CLK                   (I_REF_CLK),
		.I_SYS_RST                   (I_SYS_RST),
		.i_psel                      (i_psel),
		.i_penable                   (i_penable),
		.i_pwrite                    (i_pwrite),
		.i_paddr                     (i_paddr),
		.i_pwdata                    (i_pwdata),
		.i_pstrb                     (i_pstrb),
		.o_pready                    (o_pready),
		.o_pslverr                   (o_pslverr),
		.o_prdata                    (o_prdata),
		.i_low_req                   (i_low_req),
		.i_low_enable                (i_low_enable),
		.i_low_async                 (i_low_async),
		.i_ext_pin_req               (i_ext_pin_req),
		.i_die_link_req              (i_die_link_req),
		.i_die_link_present          (i_die_link_present),
		.i_nonmaskable_pin_request   (i_nonmaskable_pin_request),
		.i_die_link_error_req        (i_die_link_error_req),
		.i_soft_trap_instruction     (i_soft_trap_instruction),
		.i_background_debug_mode_req (i_background_debug_mode_req),
		.i_opcode_trap               (i_opcode_trap),
		.i_reset_main                (i_reset_main),
		.i_reset_clock_monitor       (i_reset_clock_monitor),
		.i_reset_watchdog_timeout    (i_reset_watchdog_timeout),
		.i_low_mask_flag             (i_low_mask_flag),
		.i_high_mask_flag            (i_high_mask_flag),
		.i_debug_active              (i_debug_active),
		.i_wait_mode                 (i_wait_mode),
		.i_stop_mode                 (i_stop_mode),
		.i_vector_req                (i_vector_req),
		.o_vector_valid              (o_vector_valid),
		.o_vector                    (o_vector),
		.o_wake                      (o_wake),
		.o_wake_enter_service        (o_wake_enter_service)
	);
	evp_core_model u_core (.clk(I_REF_CLK), .vld(o_vector_valid), .req(i_vector_req));
	initial
	begin
		forever #5 I_REF_CLK = ~I_REF_CLK;
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd;
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	function automatic logic [15:0] vb(input logic [7:0] o);
		return {base, o};
	endfunction
	function automatic logic [7:0] off(input int i);
		return 8'(130 + 2 * i);
	endfunction
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			error_cnt++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic end_of_test;
		if (error_cnt == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic clr;
		{i_low_req, i_low_enable, i_low_async, i_ext_pin_req, i_die_link_req, i_die_link_present,
			i_nonmaskable_pin_request, i_die_link_error_req, i_opcode_trap, i_soft_trap_instruction,
			i_background_debug_mode_req, i_reset_main, i_reset_clock_monitor, i_reset_watchdog_timeout,
			i_low_mask_flag, i_high_mask_flag, i_debug_active, i_wait_mode, i_stop_mode} <= '0;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		if (!w)
			q.push_back(d);
		eq.push_back({31'h0, (a != VECTOR_BASE_UPPER_ADDR && a != STATUS_ADDR)
			|| (w && a == STATUS_ADDR)});
		i_psel <= 1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge I_REF_CLK);
		i_penable <= 1;
		do @(posedge I_REF_CLK); while (o_pready !== 1'b1);
		i_psel <= 0;
		i_penable <= 0;
		@(posedge I_REF_CLK);
	endtask
	task automatic t(input logic [15:0] e);
		q.push_back({16'h0, e});
		u_core.fetch(int'(rnd() % 3));
		clr;
		@(posedge I_REF_CLK);
	endtask
	task automatic w(input logic [1:0] e);
		@(posedge I_REF_CLK);
		#1 chk("wake", {o_wake, o_wake_enter_service}, e);
		@(posedge I_REF_CLK);
		clr;
		@(posedge I_REF_CLK);
	endtask
	task automatic wk(input logic [3:0] m, input logic [1:0] e);
		{i_wait_mode, i_stop_mode, i_low_async[0], i_low_mask_flag} <= m;
		i_low_req[0] <= 1;
		i_low_enable[0] <= 1;
		w(e);
	endtask
	// ----------------------------------------
	// result watcher
	// ----------------------------------------
	always @(posedge I_REF_CLK)
	begin
		vd <= o_vector_valid;
		if (o_vector_valid === 1'b1 && vd !== 1'b1)
			chk("vector", {16'h0, o_vector}, q.pop_front());
		if (i_psel && i_penable && o_pready === 1'b1 && !i_pwrite)
			chk("prdata", o_prdata, q.pop_front());
		if (i_psel && i_penable && o_pready === 1'b1)
			chk("pslverr", {31'h0, o_pslverr}, eq.pop_front());
	end
	initial
	begin
		repeat (20000) @(posedge I_REF_CLK);
		error_cnt++;
		end_of_test;
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial
	begin
		clr;
		repeat (20) @(posedge I_REF_CLK);
		I_SYS_RST <= 0;
		@(posedge I_REF_CLK);
		apb(0, 12'h000, 32'hff);
		apb(1, 12'h000, 32'h12);
		base = 8'h12;
		apb(1, 12'h008, 32'h34);
		apb(0, 12'h000, 32'h12);
		{i_reset_main, i_reset_clock_monitor, i_reset_watchdog_timeout} <= 3'b111;
		t(16'hfffe);
		{i_reset_clock_monitor, i_reset_watchdog_timeout} <= 2'b11;
		t(16'hfffc);
		{i_reset_watchdog_timeout, i_opcode_trap} <= 2'b11;
		t(16'hfffa);
		t(vb(OFS_SPURIOUS));
		repeat (6)
		begin
			k = int'(rnd() % 55);
			i_low_enable <= '1;
			i_low_req <= (one << k) | (one << (k / 2));
			t(vb(off(k)));
		end
		i_low_req <= (one << k) | (one << 55);
		i_low_enable <= one << k;
		t(vb(off(k)));
		{i_low_req, i_low_enable, i_low_mask_flag} <= {one << k, {LOW_SOURCES{1'b1}}, 1'b1};
		t(vb(OFS_SPURIOUS));
		{i_ext_pin_req, i_low_enable, i_low_req} <= {1'b1, {LOW_SOURCES{1'b1}}, one << k};
		t(vb(OFS_EXT_PIN));
		{i_die_link_present, i_die_link_req, i_low_enable} <= {2'b11, {LOW_SOURCES{1'b1}}};
		t(vb(OFS_EXT_PIN));
		{i_nonmaskable_pin_request, i_low_enable, i_low_req} <= {1'b1, {2 * LOW_SOURCES{1'b1}}};
		t(vb(OFS_HIGH_MASK));
		{i_nonmaskable_pin_request, i_high_mask_flag} <= 2'b11;
		{i_low_enable, i_low_req} <= {one << k, one << k};
		t(vb(off(k)));
		{i_die_link_present, i_die_link_error_req} <= 2'b11;
		t(vb(OFS_HIGH_MASK));
		{i_soft_trap_instruction, i_nonmaskable_pin_request} <= 2'b11;
		t(vb(OFS_SOFT_TRAP));
		i_background_debug_mode_req <= 1;
		t(vb(OFS_SOFT_TRAP));
		{i_opcode_trap, i_soft_trap_instruction, i_nonmaskable_pin_request} <= 3'b111;
		t(vb(OFS_OPCODE));
		{i_debug_active, i_opcode_trap} <= 2'b11;
		t(16'hfff8);
		wk(4'b1000, 2'b11);
		wk(4'b0110, 2'b11);
		wk(4'b0100, 2'b00);
		wk(4'b0111, 2'b00);
		{i_nonmaskable_pin_request, i_high_mask_flag} <= 2'b11;
		w(2'b10);
		i_debug_active <= 1;
		apb(0, STATUS_ADDR, 32'h1);
		apb(1, STATUS_ADDR, 32'h0);
		clr;
		I_SYS_RST <= 1;
		@(posedge I_REF_CLK);
		I_SYS_RST <= 0;
		base = 8'hff;
		@(posedge I_REF_CLK);
		apb(0, 12'h000, 32'hff);
		t(vb(OFS_SPURIOUS));
		end_of_test;
	end
endmodule
`default_nettype wire
